// ==== rtl/timer16_pkg.sv ====
// Contract
// - atomic bit selects 16-bit or split access
// - time-base code steers capture/compare units
// - prescale select divides by 1,2,4,8
// - external source: sync bit picks sync mode
// - internal source ignores the sync bit
// - external rising edges counted after falling edge
// - internal source counts at quarter clock
// - run bit low holds the count
// - crystal enabled forces pins input, reads zero
// - atomic high address is buffer, low read fills
// - atomic low write moves buffer into count
// - only low-byte writes clear the prescaler
// - count wraps ffff to zero, sets flag
// - flag gated by enable onto interrupt request
// - control register resets to all zero
// - special event trigger zeroes count, no flag
// - write beats trigger; async mode ignores trigger
package timer16_pkg;
    // word-aligned register byte addresses on the bus
    localparam logic [4:0] ADR_CONTROL = 5'h00;
    localparam logic [4:0] ADR_COUNT_LOW = 5'h04;
    localparam logic [4:0] ADR_COUNT_HIGH = 5'h08;
    localparam logic [4:0] ADR_FLAG = 5'h0c;
    localparam logic [4:0] ADR_IRQ_ENABLE = 5'h10;
    // control register field positions
    localparam int unsigned CTL_RUN_BIT = 0;
    localparam int unsigned CTL_SRC_BIT = 1;
    localparam int unsigned CTL_NOSYNC_BIT = 2;
    localparam int unsigned CTL_TB_LO_BIT = 3;
    localparam int unsigned CTL_PS_LSB = 4;
    localparam int unsigned CTL_TB_HI_BIT = 6;
    localparam int unsigned CTL_ATOMIC_BIT = 7;
    // flag and enable registers hold their bit at position 1
    localparam int unsigned OVF_BIT = 1;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    // instruction clock is one in four system clocks
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    // time-base select codes
    localparam logic [1:0] TB_ALL_OTHER = 2'h0;
    localparam logic [1:0] TB_FROM_TWO = 2'h1;
    localparam logic [1:0] TB_FROM_THREE = 2'h2;
    localparam logic [1:0] TB_ALL_THIS = 2'h3;
    localparam logic [4:0] UNITS_NONE = 5'h00;
    localparam logic [4:0] UNITS_TWO_UP = 5'h1e;
    localparam logic [4:0] UNITS_THREE_UP = 5'h1c;
    localparam logic [4:0] UNITS_ALL = 5'h1f;
    // last prescaler count per prescale code
    localparam logic [2:0] PS_LAST_DIV1 = 3'h0;
    localparam logic [2:0] PS_LAST_DIV2 = 3'h1;
    localparam logic [2:0] PS_LAST_DIV4 = 3'h3;
    localparam logic [2:0] PS_LAST_DIV8 = 3'h7;
endpackage

// ==== rtl/level_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for pin levels; first stage feeds only the second
module level_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // metastability guard before any logic looks at the pins
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // level_sync

// ==== rtl/timer16.sv ====
`timescale 1ns/1ps
// sixteen bit timer/counter with wishbone classic register access
module timer16 (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [4:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic ext_clock_pin_in,
    input wire logic crystal_in_pin_in,
    input wire logic crystal_osc_enable_in,
    input wire logic [1:0] port_direction_in,
    input wire logic [1:0] port_data_in,
    output logic [1:0] pin_out_out,
    output logic [1:0] pin_oe_out,
    output logic [1:0] port_read_out,
    input wire logic [4:0] special_event_in,
    output logic [4:0] time_base_sel_out,
    output logic [15:0] count_out,
    output logic overflow_pulse_out,
    output logic irq_req_out
);
    logic [7:0] ctl_r;
    logic [15:0] count_r;
    logic [7:0] high_buf_r;
    logic flag_r;
    logic irq_en_r;
    logic [2:0] ps_cnt_r;
    logic [1:0] quarter_r;
    logic armed_r;
    logic prev_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [1:0] port_read_r;
    logic ovf_pulse_r;
    logic [1:0] pins_s;
    logic ext_level;
    logic ext_rise;
    logic q_tick;
    logic src_edge;
    logic inc;
    logic ovf;
    logic evt_reset;
    logic req;
    logic wr;
    logic wr_ctl;
    logic wr_low;
    logic wr_high;
    logic wr_flag;
    logic wr_en;
    logic rd_low;
    logic atomic;
    logic run;
    logic ext_src;
    logic [2:0] ps_last;
    logic [31:0] rd_val;

    // units served by this timer pair for a time-base code
    function automatic logic [4:0] units_of(input logic [1:0] code);
        case (code)
            timer16_pkg::TB_ALL_THIS: units_of = timer16_pkg::UNITS_ALL;
            timer16_pkg::TB_FROM_THREE: units_of = timer16_pkg::UNITS_THREE_UP;
            timer16_pkg::TB_FROM_TWO: units_of = timer16_pkg::UNITS_TWO_UP;
            default: units_of = timer16_pkg::UNITS_NONE;
        endcase
    endfunction

    // last prescaler count for a prescale code
    function automatic logic [2:0] ps_last_of(input logic [1:0] code);
        case (code)
            2'h3: ps_last_of = timer16_pkg::PS_LAST_DIV8;
            2'h2: ps_last_of = timer16_pkg::PS_LAST_DIV4;
            2'h1: ps_last_of = timer16_pkg::PS_LAST_DIV2;
            default: ps_last_of = timer16_pkg::PS_LAST_DIV1;
        endcase
    endfunction

    // pins never feed logic before two flops
    level_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in({crystal_in_pin_in, ext_clock_pin_in}),
        .sync_out(pins_s)
    );

    // bus decode; side effects fire on the edge that raises ack
    assign req = wb_cyc_in & wb_stb_in & ~ack_r;
    assign wr = req & wb_we_in & wb_sel_in[0];
    assign wr_ctl = wr & (wb_adr_in == timer16_pkg::ADR_CONTROL);
    assign wr_low = wr & (wb_adr_in == timer16_pkg::ADR_COUNT_LOW);
    assign wr_high = wr & (wb_adr_in == timer16_pkg::ADR_COUNT_HIGH);
    assign wr_flag = wr & (wb_adr_in == timer16_pkg::ADR_FLAG);
    assign wr_en = wr & (wb_adr_in == timer16_pkg::ADR_IRQ_ENABLE);
    assign rd_low = req & ~wb_we_in & (wb_adr_in == timer16_pkg::ADR_COUNT_LOW);

    // control fields
    assign atomic = ctl_r[timer16_pkg::CTL_ATOMIC_BIT];
    assign run = ctl_r[timer16_pkg::CTL_RUN_BIT];
    assign ext_src = ctl_r[timer16_pkg::CTL_SRC_BIT];
    assign ps_last = ps_last_of(ctl_r[timer16_pkg::CTL_PS_LSB +: 2]);
    assign time_base_sel_out = units_of({ctl_r[timer16_pkg::CTL_TB_HI_BIT],
                                         ctl_r[timer16_pkg::CTL_TB_LO_BIT]});

    // external clock: crystal when the companion enables it, else the pin
    // both sync and unsync modes see the double-flopped level here, since
    // this block has one clock; unsync only changes trigger handling
    assign ext_level = crystal_osc_enable_in ? pins_s[1] : pins_s[0];
    assign ext_rise = ext_level & ~prev_r;
    assign q_tick = (quarter_r == timer16_pkg::QUARTER_LAST);
    // internal source ignores the sync bit entirely
    assign src_edge = ext_src ? (ext_rise & armed_r) : q_tick;
    // compare with >= so that a smaller prescale takes effect at once, not after a 3-bit wrap
    assign inc = src_edge & run & (ps_cnt_r >= ps_last);
    // a trigger in the same cycle zeroes the count instead, so no wrap is seen
    assign ovf = inc & (count_r == timer16_pkg::COUNT_MAX) & ~evt_reset;
    // unsynced counting drops the trigger; keeps software off the hazard
    assign evt_reset = |(special_event_in & time_base_sel_out)
                       & ~(ext_src & ctl_r[timer16_pkg::CTL_NOSYNC_BIT]);

    // free-running quarter divider for the instruction clock
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            quarter_r <= 2'h0;
        end else begin
            quarter_r <= quarter_r + 2'h1;
        end
    end

    // edge history and first-falling-edge arming
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            prev_r <= ext_level;
            if (!run || !ext_src) begin
                armed_r <= 1'b0;
            end else if (!ext_level) begin
                armed_r <= 1'b1;
            end
        end
    end

    // control register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctl_r <= timer16_pkg::CONTROL_RESET;
        end else if (wr_ctl) begin
            ctl_r <= wb_dat_in[7:0];
        end
    end

    // prescaler: low-byte writes clear it, high-byte writes do not
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ps_cnt_r <= 3'h0;
        end else if (wr_low) begin
            ps_cnt_r <= 3'h0;
        end else if (src_edge && run) begin
            ps_cnt_r <= inc ? 3'h0 : ps_cnt_r + 3'h1;
        end
    end

    // count: software write first, then trigger, then increment
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_r <= timer16_pkg::COUNT_RESET;
        end else if (wr_low && atomic) begin
            count_r <= {high_buf_r, wb_dat_in[7:0]};
        end else if (wr_low) begin
            count_r <= {count_r[15:8], wb_dat_in[7:0]};
        end else if (wr_high && !atomic) begin
            count_r <= {wb_dat_in[7:0], count_r[7:0]};
        end else if (evt_reset) begin
            count_r <= timer16_pkg::COUNT_RESET;
        end else if (inc) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // high byte buffer for atomic access
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            high_buf_r <= 8'h00;
        end else if (wr_high && atomic) begin
            high_buf_r <= wb_dat_in[7:0];
        end else if (rd_low && atomic) begin
            high_buf_r <= count_r[15:8];
        end
    end

    // overflow flag: hardware set wins over software clear
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flag_r <= 1'b0;
            irq_en_r <= 1'b0;
            ovf_pulse_r <= 1'b0;
        end else begin
            ovf_pulse_r <= ovf & ~wr_low & ~(wr_high & ~atomic);
            if (ovf && !wr_low && !(wr_high && !atomic)) begin
                flag_r <= 1'b1;
            end else if (wr_flag) begin
                flag_r <= wb_dat_in[timer16_pkg::OVF_BIT];
            end
            if (wr_en) begin
                irq_en_r <= wb_dat_in[timer16_pkg::OVF_BIT];
            end
        end
    end

    // read mux; atomic high address shows the buffer
    always_comb begin
        rd_val = 32'h0000_0000;
        case (wb_adr_in)
            timer16_pkg::ADR_CONTROL: rd_val[7:0] = ctl_r;
            timer16_pkg::ADR_COUNT_LOW: rd_val[7:0] = count_r[7:0];
            timer16_pkg::ADR_COUNT_HIGH: rd_val[7:0] = atomic ? high_buf_r : count_r[15:8];
            timer16_pkg::ADR_FLAG: rd_val[timer16_pkg::OVF_BIT] = flag_r;
            timer16_pkg::ADR_IRQ_ENABLE: rd_val[timer16_pkg::OVF_BIT] = irq_en_r;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // single wait state; unmapped addresses ack with zero
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            if (req && !wb_we_in) begin
                dat_r <= rd_val;
            end
        end
    end

    // pin port view: crystal takes both pins as inputs reading zero
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            port_read_r <= 2'h0;
        end else begin
            port_read_r <= crystal_osc_enable_in ? 2'h0 : {pins_s[1], pins_s[0]};
        end
    end

    assign pin_oe_out = crystal_osc_enable_in ? 2'h0 : ~port_direction_in;
    assign pin_out_out = port_data_in;
    assign port_read_out = port_read_r;
    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;
    assign count_out = count_r;
    assign overflow_pulse_out = ovf_pulse_r;
    assign irq_req_out = flag_r & irq_en_r;

    a_run_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!run && !wr_low && !wr_high && !evt_reset) |=> (count_r == $past(count_r)))
        else $error("count moved while stopped");

    a_wrap_flag: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ovf && !wr_low && !wr_high && !evt_reset) |=> (flag_r && count_r == 16'h0000))
        else $error("wrap did not clear count and set flag");

    a_irq_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!irq_en_r || !flag_r) |-> !irq_req_out)
        else $error("interrupt request without flag and enable");

    a_prescale_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_low |=> (ps_cnt_r == 3'h0))
        else $error("low write did not clear prescaler");

    a_high_keeps_ps: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_high && !(src_edge && run)) |=> (ps_cnt_r == $past(ps_cnt_r)))
        else $error("high write touched prescaler");

    a_atomic_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_low && atomic) |=> (count_r == {$past(high_buf_r), $past(wb_dat_in[7:0])}))
        else $error("atomic low write did not load both bytes");

    a_atomic_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_high && atomic && !inc && !evt_reset) |=> (count_r == $past(count_r)))
        else $error("atomic high write reached the live count");

    a_read_copy: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rd_low && atomic) |=> (high_buf_r == $past(count_r[15:8])))
        else $error("low read did not latch high byte");

    a_event_reset: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (evt_reset && !wr_low && !wr_high && !wr_flag) |=> (count_r == 16'h0000 && !$rose(flag_r)))
        else $error("trigger did not zero count or set flag");

    a_first_fall: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ext_src && !armed_r) |-> !src_edge)
        else $error("external edge counted before a falling edge");

    a_tb_decode: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ctl_r[timer16_pkg::CTL_TB_HI_BIT] && !ctl_r[timer16_pkg::CTL_TB_LO_BIT])
        |-> (time_base_sel_out == 5'h1c))
        else $error("time base code 10 decoded wrongly");

    a_crystal_pins: assert property (@(posedge clk_in) disable iff (!resetn_in)
        crystal_osc_enable_in |-> (pin_oe_out == 2'h0) ##1 (!crystal_osc_enable_in || port_read_out == 2'h0))
        else $error("crystal pins driven or read nonzero");

    // count source, prescale, split write, write priority, flag hold and trigger pulse checks
    a_int_tick: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (run && !ext_src && !q_tick && !wr_low && !wr_high && !evt_reset) |=> (count_r == $past(count_r)))
        else $error("internal count moved between quarter ticks");

    a_ext_edge_only: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ext_src && !ext_rise && !wr_low && !wr_high && !evt_reset) |=> (count_r == $past(count_r)))
        else $error("external count moved without a rising edge");

    a_div1_step: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (run && ctl_r[timer16_pkg::CTL_PS_LSB +: 2] == 2'h0 && src_edge && !wr_low && !wr_high && !evt_reset)
        |=> (count_r == $past(count_r) + 16'h0001))
        else $error("undivided source edge did not advance the count");

    a_split_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_high && !atomic) |=> (count_r[15:8] == $past(wb_dat_in[7:0])))
        else $error("split high write did not load the live high byte");

    a_split_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_low && !atomic) |=> (count_r == {$past(count_r[15:8]), $past(wb_dat_in[7:0])}))
        else $error("split low write did not load only the low byte");

    a_write_wins: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_low && evt_reset) |=> (count_r[7:0] == $past(wb_dat_in[7:0])))
        else $error("trigger overrode a coinciding low write");

    a_flag_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!ovf && !wr_flag) |=> (flag_r == $past(flag_r)))
        else $error("flag changed without wrap or write");

    a_event_no_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
        evt_reset |=> !overflow_pulse_out)
        else $error("trigger produced an overflow pulse");
endmodule // timer16

// ==== dv/ext_clock_model.sv ====
`timescale 1ns/1ps
// far-side count source: the selected line toggles in earnest, the other one wiggles fast
module ext_clock_model #(
    parameter realtime HALF_NS = 37.0
) (
    input wire logic run_in,
    input wire logic use_crystal_in,
    output logic pin_out,
    output logic crystal_out,
    output logic [15:0] rise_count_out
);
    logic level;
    logic noise;
    // starts high and stands still at its last level when stopped, so its first rise follows a fall
    initial begin
        level = 1'b1;
        rise_count_out = 16'h0000;
        forever begin
            #(HALF_NS);
            if (run_in) begin
                level = ~level;
                if (level) rise_count_out = rise_count_out + 16'h0001;
            end
        end
    end
    // noise on the unused line makes a wrong source choice show up as a wrong count
    initial begin
        noise = 1'b0;
        forever #(HALF_NS / 3.0) noise = ~noise;
    end
    assign pin_out = use_crystal_in ? noise : level;
    assign crystal_out = use_crystal_in ? level : noise;
endmodule // ext_clock_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
// register-level bench driving the timer over classic wishbone
module testbench;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [4:0] wb_adr = 5'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic ext_pin;
    logic xtal_pin;
    logic ext_run = 1'b0;
    logic use_xtal = 1'b0;
    logic xtal_en = 1'b0;
    logic [4:0] trig = 5'h00;
    logic [4:0] trig_mask = 5'h00;
    logic [1:0] pin_oe;
    logic [1:0] port_rd;
    logic [1:0] pin_drv;
    logic [4:0] tb_sel;
    logic [15:0] count;
    logic [15:0] rises;
    logic [15:0] snap;
    logic ovf;
    logic irq;
    logic [7:0] q;
    logic [7:0] tb_ctl [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
    logic [4:0] tb_exp [4] = '{5'h00, 5'h1e, 5'h1c, 5'h1f};
    int fails = 0;
    int total_checks = 0;
    int n;

    always #4 clk_in = ~clk_in;

    timer16 u_timer16 (.clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_rdat),
        .wb_ack_out(wb_ack), .ext_clock_pin_in(ext_pin), .crystal_in_pin_in(xtal_pin),
        .crystal_osc_enable_in(xtal_en), .port_direction_in(2'h1), .port_data_in(2'h2), .pin_out_out(pin_drv),
        .pin_oe_out(pin_oe), .port_read_out(port_rd), .special_event_in(trig), .time_base_sel_out(tb_sel),
        .count_out(count), .overflow_pulse_out(ovf), .irq_req_out(irq));

    ext_clock_model u_ext_clock_model (.run_in(ext_run), .use_crystal_in(use_xtal), .pin_out(ext_pin),
        .crystal_out(xtal_pin), .rise_count_out(rises));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle held until ack is sampled; trig_mask rides on the taking edge only
    task automatic xfer(input logic we, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'h1;
        wb_dat <= {24'h00_0000, d};
        trig <= trig_mask;
        do begin
            @(posedge clk_in);
            trig <= 5'h00;
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        q = wb_rdat[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (k >= 20) begin
            fails++;
            report_and_stop();
        end
        @(posedge clk_in);
    endtask

    task automatic rd_check(input logic [4:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        check({8'h00, q}, {8'h00, exp});
    endtask

    // cycles until the live count next moves; bounded at 200 so a stuck count fails and ends the run
    task automatic step_time(output int c);
        logic [15:0] last;
        last = count;
        c = 0;
        do begin
            @(posedge clk_in);
            c++;
        end while (count === last && c < 200);
        if (count === last) begin
            fails++;
            report_and_stop();
        end
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        rd_check(timer16_pkg::ADR_CONTROL, 8'h00);
        xfer(1'b1, 5'h14, 8'hff);
        rd_check(5'h14, 8'h00);
        // split access loads each byte straight into the count
        xfer(1'b1, timer16_pkg::ADR_COUNT_LOW, 8'h34);
        xfer(1'b1, timer16_pkg::ADR_COUNT_HIGH, 8'h12);
        check(count, 16'h1234);
        // atomic mode: high byte waits in the buffer until the low write
        xfer(1'b1, timer16_pkg::ADR_CONTROL, 8'h80);
        xfer(1'b1, timer16_pkg::ADR_COUNT_HIGH, 8'hab);
        check(count, 16'h1234);
        xfer(1'b1, timer16_pkg::ADR_COUNT_LOW, 8'hcd);
        check(count, 16'habcd);
        xfer(1'b1, timer16_pkg::ADR_COUNT_HIGH, 8'h55);
        rd_check(timer16_pkg::ADR_COUNT_HIGH, 8'h55);
        rd_check(timer16_pkg::ADR_COUNT_LOW, 8'hcd);
        rd_check(timer16_pkg::ADR_COUNT_HIGH, 8'hab);
        // every time-base code
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, timer16_pkg::ADR_CONTROL, tb_ctl[i]);
            check({11'h000, tb_sel}, {11'h000, tb_exp[i]});
        end
        // trigger zeroes the count without a flag; a coinciding write wins
        trig <= 5'h10;
        @(posedge clk_in);
        trig <= 5'h00;
        repeat (2) @(posedge clk_in);
        check(count, 16'h0000);
        rd_check(timer16_pkg::ADR_FLAG, 8'h00);
        xfer(1'b1, timer16_pkg::ADR_COUNT_HIGH, 8'h12);
        trig_mask = 5'h01;
        xfer(1'b1, timer16_pkg::ADR_COUNT_LOW, 8'h77);
        trig_mask = 5'h00;
        check(count, 16'h1277);
        // internal source with the sync bit set: period is four clocks times the prescale
        for (int ps = 0; ps < 4; ps++) begin
            xfer(1'b1, timer16_pkg::ADR_CONTROL, 8'h05 | 8'(ps << 4));
            step_time(n);
            step_time(n);
            check(16'(n), 16'(4 << ps));
        end
        xfer(1'b1, timer16_pkg::ADR_CONTROL, 8'h00);
        snap = count;
        repeat (40) @(posedge clk_in);
        check(count, snap);
        // wrap from the top sets the flag; the request follows the enable
        xfer(1'b1, timer16_pkg::ADR_COUNT_HIGH, 8'hff);
        xfer(1'b1, timer16_pkg::ADR_COUNT_LOW, 8'hff);
        xfer(1'b1, timer16_pkg::ADR_CONTROL, 8'h01);
        n = 0;
        while (ovf !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        if (ovf !== 1'b1) begin
            fails++;
            report_and_stop();
        end
        check(count, 16'h0000);
        xfer(1'b1, timer16_pkg::ADR_CONTROL, 8'h00);
        rd_check(timer16_pkg::ADR_FLAG, 8'h02);
        check({15'h0000, irq}, 16'h0000);
        xfer(1'b1, timer16_pkg::ADR_IRQ_ENABLE, 8'h02);
        check({15'h0000, irq}, 16'h0001);
        xfer(1'b1, timer16_pkg::ADR_FLAG, 8'h00);
        check({15'h0000, irq}, 16'h0000);
        // synchronised pin counting; the pin sat high, so its first edge is a fall and every rise must count
        xfer(1'b1, timer16_pkg::ADR_COUNT_HIGH, 8'h00);
        xfer(1'b1, timer16_pkg::ADR_CONTROL, 8'h03);
        xfer(1'b1, timer16_pkg::ADR_COUNT_LOW, 8'h00);
        check({12'h000, pin_drv, pin_oe}, 16'h000a);
        snap = rises;
        ext_run <= 1'b1;
        repeat (300) @(posedge clk_in);
        ext_run <= 1'b0;
        repeat (10) @(posedge clk_in);
        check(count, rises - snap);
        // crystal needs its enable plus the source bit; synced mode since the cpu clock is not it
        xtal_en <= 1'b1;
        use_xtal <= 1'b1;
        // let the old line's level leave the synchroniser before zeroing, or it counts as an edge
        repeat (4) @(posedge clk_in);
        xfer(1'b1, timer16_pkg::ADR_COUNT_LOW, 8'h00);
        snap = rises;
        ext_run <= 1'b1;
        repeat (300) @(posedge clk_in);
        check({12'h000, pin_oe, port_rd}, 16'h0000);
        ext_run <= 1'b0;
        repeat (10) @(posedge clk_in);
        check(count, rises - snap);
        report_and_stop();
    end
endmodule // testbench
